// file: verilog/lscr_regs.sv
// lscr_regs: sleep, control and power-on settings of two regulator channels,
// with undervoltage handling and interrupt status
// assumes a same-clock register master and asynchronous control/undervoltage pins
`timescale 1ns/100ps
module lscr_regs (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic [lscr_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [lscr_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [lscr_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                          ch6_hwen_assigned,
  input  wire logic                          hwctl1_pin,
  input  wire logic                          hwctl2_pin,
  input  wire logic                          ch7_uv_pin,
  output lscr_pkg::lscr_ch6_out_t            ch6_out,
  output lscr_pkg::lscr_ch7_out_t            ch7_out,
  output logic                               irq
);
  import lscr_pkg::*;

  typedef struct packed {
    lscr_regs_t        regs;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq;
    logic              uv_prev;
    logic              hw_prev;
    logic [DATA_W-1:0] rdata;
    lscr_ch6_out_t     ch6;
    lscr_ch7_out_t     ch7;
  } lscr_state_t;

  localparam lscr_regs_t REGS_RST = '{
    ch6_sleep_lowpower:  SLP_MODE_RST,
    ch7_hwctl_opmode:    HWMODE_RST,
    default:             '0
  };

  lscr_state_t     s_q;
  lscr_state_t     s_d;
  logic [PIN_W-1:0] pins_sync;

  // pins come from outside the clock domain
  lscr_sync #(
    .WIDTH (PIN_W)
  ) i_lscr_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pin_async ({ch7_uv_pin, hwctl2_pin, hwctl1_pin}),
    .pin_sync  (pins_sync)
  );

  // read-back image: only defined fields, everything else zero
  function automatic logic [DATA_W-1:0] read_word(input lscr_regs_t r,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic [IRQ_W-1:0] st,
                                                  input logic [IRQ_W-1:0] en);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      ADDR_CH6_SLEEP: begin
        w[SLOT_LSB +: SLOT_W] = r.ch6_sleep_timeslot;
        w[MODE_BIT]           = r.ch6_sleep_lowpower;
        w[VSEL_LSB +: VSEL_W] = r.ch6_sleep_volt_code;
      end
      ADDR_CH7_CTRL: begin
        w[UVACT_LSB +: 2]  = r.ch7_uv_action;
        w[HWSRC_LSB +: 2]  = r.ch7_hwctl_source;
        w[HWVSEL_BIT]      = r.ch7_hwctl_volt_pick;
        w[HWMODE_LSB +: 2] = r.ch7_hwctl_opmode;
        w[FLT_BIT]         = r.ch7_output_float;
        w[SWI_BIT]         = r.ch7_switch_mode;
      end
      ADDR_CH7_ON: begin
        w[SLOT_LSB +: SLOT_W] = r.ch7_poweron_timeslot;
        w[MODE_BIT]           = r.ch7_poweron_lowpower;
        w[VSEL_LSB +: VSEL_W] = r.ch7_poweron_volt_code;
      end
      ADDR_CH7_SLEEP: w[VSEL_LSB +: VSEL_W] = r.ch7_sleep_volt_code;
      ADDR_IRQ_STAT:  w[IRQ_W-1:0] = st;
      ADDR_IRQ_EN:    w[IRQ_W-1:0] = en;
      default:        w = '0;
    endcase
    return w;
  endfunction : read_word

  // hardware control input selection
  function automatic logic hw_asserted(input logic [1:0] src,
                                       input logic       h1,
                                       input logic       h2);
    case (src)
      HWSRC_OFF: return 1'b0;
      HWSRC_1:   return h1;
      HWSRC_2:   return h2;
      HWSRC_ANY: return h1 | h2;
      default:   return 1'b0;
    endcase
  endfunction : hw_asserted

  logic              uv_now;
  logic              uv_edge;
  logic              hw_act;
  logic              hw_change;
  logic [VSEL_W-1:0] ch7_code;
  logic [IRQ_W-1:0]  evt;
  logic [IRQ_W-1:0]  clr;
  lscr_slot_t        ch6_slot;

  always_comb begin
    s_d       = s_q;
    uv_now    = pins_sync[PIN_UV];
    uv_edge   = uv_now & ~s_q.uv_prev;
    hw_act    = hw_asserted(s_q.regs.ch7_hwctl_source,
                            pins_sync[PIN_HWC1], pins_sync[PIN_HWC2]);
    hw_change = hw_act ^ s_q.hw_prev;
    evt       = '0;
    clr       = '0;
    ch6_slot  = lscr_sleep_slot(s_q.regs.ch6_sleep_timeslot);
    ch7_code  = s_q.regs.ch7_poweron_volt_code;

    if (ce) begin
      s_d.uv_prev = uv_now;
      s_d.hw_prev = hw_act;

      // register writes; bits outside the fields are dropped
      if (reg_wr) begin
        case (reg_addr)
          ADDR_CH6_SLEEP: begin
            s_d.regs.ch6_sleep_timeslot  = reg_wdata[SLOT_LSB +: SLOT_W];
            s_d.regs.ch6_sleep_lowpower  = reg_wdata[MODE_BIT];
            s_d.regs.ch6_sleep_volt_code = reg_wdata[VSEL_LSB +: VSEL_W];
          end
          ADDR_CH7_CTRL: begin
            s_d.regs.ch7_uv_action       = reg_wdata[UVACT_LSB +: 2];
            s_d.regs.ch7_hwctl_source    = reg_wdata[HWSRC_LSB +: 2];
            s_d.regs.ch7_hwctl_volt_pick = reg_wdata[HWVSEL_BIT];
            s_d.regs.ch7_hwctl_opmode    = reg_wdata[HWMODE_LSB +: 2];
            s_d.regs.ch7_output_float    = reg_wdata[FLT_BIT];
            s_d.regs.ch7_switch_mode     = reg_wdata[SWI_BIT];
          end
          ADDR_CH7_ON: begin
            s_d.regs.ch7_poweron_timeslot  = reg_wdata[SLOT_LSB +: SLOT_W];
            s_d.regs.ch7_poweron_lowpower  = reg_wdata[MODE_BIT];
            s_d.regs.ch7_poweron_volt_code = reg_wdata[VSEL_LSB +: VSEL_W];
          end
          ADDR_CH7_SLEEP: s_d.regs.ch7_sleep_volt_code = reg_wdata[VSEL_LSB +: VSEL_W];
          ADDR_IRQ_CLR:   clr = reg_wdata[IRQ_W-1:0];
          ADDR_IRQ_EN:    s_d.irq_en = reg_wdata[IRQ_W-1:0];
          default:        ;
        endcase
      end

      // read data stands only in the cycle after the strobe
      s_d.rdata = reg_rd ? read_word(s_q.regs, reg_addr, s_q.irq_stat, s_q.irq_en)
                         : '0;

      // channel a sleep outputs
      s_d.ch6.sleep_slot     = ch6_slot.slot;
      s_d.ch6.sleep_off      = ch6_slot.off & ~ch6_hwen_assigned;
      s_d.ch6.sleep_enter_hw = ch6_slot.off & ch6_hwen_assigned;
      s_d.ch6.sleep_lowpower = s_q.regs.ch6_sleep_lowpower;
      s_d.ch6.sleep_mv       = lscr_volt_mv(s_q.regs.ch6_sleep_volt_code,
                                            CH6_BASE_MV, CH6_KNEE);

      // channel b voltage and mode under hardware control
      if (hw_act && s_q.regs.ch7_hwctl_volt_pick) begin
        ch7_code = s_q.regs.ch7_sleep_volt_code;
      end
      s_d.ch7.hwctl_active = hw_act;
      s_d.ch7.volt_mv      = lscr_volt_mv(ch7_code, CH7_BASE_MV, CH7_KNEE);
      if (hw_act) begin
        s_d.ch7.lowpower = (s_q.regs.ch7_hwctl_opmode == HWMODE_ON) ?
                           s_q.regs.ch7_poweron_lowpower : 1'b1;
      end else begin
        s_d.ch7.lowpower = s_q.regs.ch7_poweron_lowpower;
      end
      s_d.ch7.output_float = s_q.regs.ch7_output_float;
      s_d.ch7.switch_mode  = s_q.regs.ch7_switch_mode;

      // power-on slot or hardware enable hand-over
      case (s_q.regs.ch7_poweron_timeslot)
        ON_NEVER: begin
          s_d.ch7.poweron_slot = '0;
          s_d.ch7.hwen_sel     = HWEN_NONE;
        end
        ON_HWEN1: begin
          s_d.ch7.poweron_slot = '0;
          s_d.ch7.hwen_sel     = HWEN_1;
        end
        ON_HWEN2: begin
          s_d.ch7.poweron_slot = '0;
          s_d.ch7.hwen_sel     = HWEN_2;
        end
        default: begin
          s_d.ch7.poweron_slot = s_q.regs.ch7_poweron_timeslot;
          s_d.ch7.hwen_sel     = HWEN_NONE;
        end
      endcase

      // undervoltage response; reserved action behaves as ignore
      s_d.ch7.sys_reset_req = uv_edge && (s_q.regs.ch7_uv_action == UV_SYS_RST);
      if (uv_edge && (s_q.regs.ch7_uv_action == UV_REG_OFF)) begin
        s_d.ch7.uv_reg_off = 1'b1;
      end else if (clr[IRQ_UV]) begin
        s_d.ch7.uv_reg_off = 1'b0;
      end
      // a shutdown latched by undervoltage holds until software clears the event
      s_d.ch7.force_off = s_d.ch7.uv_reg_off |
                          (hw_act && (s_q.regs.ch7_hwctl_opmode == HWMODE_OFF));

      // sticky status: a new event wins over a clear in the same cycle
      evt[IRQ_UV]  = uv_edge;
      evt[IRQ_HWC] = hw_change;
      s_d.irq_stat = (s_q.irq_stat & ~clr) | evt;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_en);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.regs <= REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign ch6_out   = s_q.ch6;
  assign ch7_out   = s_q.ch7;
  assign irq       = s_q.irq;

endmodule : lscr_regs

// file: inc/lscr_pkg.sv
// lscr_pkg: constants, field layouts and carriers of the regulator sequencing control bank
// assumes a single 40 MHz clock domain and a 16-bit plain register port
package lscr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int MV_W   = 12;
  localparam int SLOT_W = 3;
  localparam int VSEL_W = 5;
  localparam int IRQ_W  = 2;
  localparam int PIN_W  = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CH6_SLEEP = 16'h4079;
  localparam logic [ADDR_W-1:0] ADDR_CH7_CTRL  = 16'h407a;
  localparam logic [ADDR_W-1:0] ADDR_CH7_ON    = 16'h407b;
  localparam logic [ADDR_W-1:0] ADDR_CH7_SLEEP = 16'h407c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 16'h4090;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR   = 16'h4091;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 16'h4092;

  // field positions
  localparam int SLOT_LSB   = 13;
  localparam int MODE_BIT   = 8;
  localparam int VSEL_LSB   = 0;
  localparam int UVACT_LSB  = 14;
  localparam int HWSRC_LSB  = 11;
  localparam int HWVSEL_BIT = 10;
  localparam int HWMODE_LSB = 8;
  localparam int FLT_BIT    = 7;
  localparam int SWI_BIT    = 6;
  localparam int IRQ_UV     = 0;
  localparam int IRQ_HWC    = 1;
  localparam int PIN_HWC1   = 0;
  localparam int PIN_HWC2   = 1;
  localparam int PIN_UV     = 2;

  // reset values
  localparam logic       SLP_MODE_RST = 1'b1;
  localparam logic [1:0] HWMODE_RST   = 2'b10;

  // codes
  localparam logic [1:0] UV_IGNORE  = 2'b00;
  localparam logic [1:0] UV_REG_OFF = 2'b01;
  localparam logic [1:0] UV_SYS_RST = 2'b10;
  localparam logic [1:0] HWSRC_OFF  = 2'b00;
  localparam logic [1:0] HWSRC_1    = 2'b01;
  localparam logic [1:0] HWSRC_2    = 2'b10;
  localparam logic [1:0] HWSRC_ANY  = 2'b11;
  localparam logic [1:0] HWMODE_OFF = 2'b01;
  localparam logic [1:0] HWMODE_ON  = 2'b11;
  localparam logic [2:0] SLP_TS5    = 3'b000;
  localparam logic [2:0] SLP_TS3    = 3'b110;
  localparam logic [2:0] SLP_TS1    = 3'b111;
  localparam logic [2:0] ON_NEVER   = 3'b000;
  localparam logic [2:0] ON_HWEN1   = 3'b110;
  localparam logic [2:0] ON_HWEN2   = 3'b111;
  localparam logic [2:0] SLOT_1     = 3'd1;
  localparam logic [2:0] SLOT_3     = 3'd3;
  localparam logic [2:0] SLOT_5     = 3'd5;
  localparam logic [2:0] SLOT_REV   = 3'd6;
  localparam logic [1:0] HWEN_NONE  = 2'b00;
  localparam logic [1:0] HWEN_1     = 2'b01;
  localparam logic [1:0] HWEN_2     = 2'b10;

  // voltage ladders
  localparam logic [MV_W-1:0]   CH6_BASE_MV   = 12'd900;
  localparam logic [VSEL_W-1:0] CH6_KNEE      = 5'h0e;
  localparam logic [MV_W-1:0]   CH7_BASE_MV   = 12'd1000;
  localparam logic [VSEL_W-1:0] CH7_KNEE      = 5'h0c;
  localparam logic [MV_W-1:0]   FINE_STEP_MV  = 12'd50;
  localparam logic [MV_W-1:0]   COARSE_STEP_MV = 12'd100;
  localparam logic [MV_W-1:0]   COARSE_BASE_MV = 12'd1700;

  typedef struct packed {
    logic [SLOT_W-1:0] ch6_sleep_timeslot;
    logic              ch6_sleep_lowpower;
    logic [VSEL_W-1:0] ch6_sleep_volt_code;
    logic [1:0]        ch7_uv_action;
    logic [1:0]        ch7_hwctl_source;
    logic              ch7_hwctl_volt_pick;
    logic [1:0]        ch7_hwctl_opmode;
    logic              ch7_output_float;
    logic              ch7_switch_mode;
    logic [SLOT_W-1:0] ch7_poweron_timeslot;
    logic              ch7_poweron_lowpower;
    logic [VSEL_W-1:0] ch7_poweron_volt_code;
    logic [VSEL_W-1:0] ch7_sleep_volt_code;
  } lscr_regs_t;

  typedef struct packed {
    logic              sleep_off;
    logic              sleep_enter_hw;
    logic [SLOT_W-1:0] sleep_slot;
    logic              sleep_lowpower;
    logic [MV_W-1:0]   sleep_mv;
  } lscr_ch6_out_t;

  typedef struct packed {
    logic              hwctl_active;
    logic              force_off;
    logic              lowpower;
    logic [MV_W-1:0]   volt_mv;
    logic              output_float;
    logic              switch_mode;
    logic [SLOT_W-1:0] poweron_slot;
    logic [1:0]        hwen_sel;
    logic              uv_reg_off;
    logic              sys_reset_req;
  } lscr_ch7_out_t;

  typedef struct packed {
    logic              off;
    logic [SLOT_W-1:0] slot;
  } lscr_slot_t;

  function automatic logic [MV_W-1:0] lscr_volt_mv(input logic [VSEL_W-1:0] code,
                                                   input logic [MV_W-1:0]   base,
                                                   input logic [VSEL_W-1:0] knee);
    logic [VSEL_W-1:0] above;
    above = VSEL_W'(code - knee - 5'd1);
    if (code <= knee) begin
      return MV_W'(base + FINE_STEP_MV * MV_W'(code));
    end
    return MV_W'(COARSE_BASE_MV + COARSE_STEP_MV * MV_W'(above));
  endfunction : lscr_volt_mv

  function automatic lscr_slot_t lscr_sleep_slot(input logic [SLOT_W-1:0] code);
    lscr_slot_t r;
    r.off  = 1'b0;
    r.slot = SLOT_5;
    case (code)
      SLP_TS5: r.slot = SLOT_5;
      SLP_TS3: r.slot = SLOT_3;
      SLP_TS1: r.slot = SLOT_1;
      default: begin
        r.off  = 1'b1;
        r.slot = SLOT_W'(SLOT_REV - code);
      end
    endcase
    return r;
  endfunction : lscr_sleep_slot

endpackage : lscr_pkg

// file: verilog/lscr_sync.sv
// lscr_sync: two-flop synchroniser for a bundle of asynchronous pins
// assumes the pins are independent levels; no bus coherence across bits
`timescale 1ns/100ps
module lscr_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);
  import lscr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lscr_sync_state_t;

  lscr_sync_state_t s_q;
  lscr_sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.meta   = pin_async;
      s_d.stable = s_q.meta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // only the second stage leaves the module
  assign pin_sync = s_q.stable;

endmodule : lscr_sync

// file: test/lscr_regs_asserts.sv
// lscr_regs_asserts: port-level checks of the regulator sequencing control bank
// assumes the single ref_clk domain; ce drops only for short idle stretches
`timescale 1ns/100ps
module lscr_regs_asserts
  import lscr_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire logic                        ce,
  input wire logic [lscr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                        reg_rd,
  input wire logic [lscr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        ch6_hwen_assigned,
  input wire logic                        ch7_uv_pin,
  input wire lscr_pkg::lscr_ch6_out_t     ch6_out,
  input wire lscr_pkg::lscr_ch7_out_t     ch7_out,
  input wire logic                        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic unmapped;
  assign unmapped = !(reg_addr inside {ADDR_CH6_SLEEP, ADDR_CH7_CTRL, ADDR_CH7_ON,
                      ADDR_CH7_SLEEP, ADDR_IRQ_STAT, ADDR_IRQ_EN});

  rdata_idle_zero_a: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (ce && reg_rd && unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  ch6_spare_bits_a: assert property (ce && reg_rd && reg_addr == ADDR_CH6_SLEEP
    |=> (reg_rdata & 16'h1ee0) == 16'h0000) else $error("channel a spare bits set");
  ch7_spare_bits_a: assert property (ce && reg_rd && reg_addr == ADDR_CH7_CTRL
    |=> (reg_rdata & 16'h203f) == 16'h0000) else $error("channel b spare bits set");
  sleep_off_slot_a: assert property (ch6_out.sleep_off
    |-> !ch6_out.sleep_enter_hw && ch6_out.sleep_slot inside {[3'd1:3'd5]})
    else $error("switch-off slot out of range");
  hw_entry_cause_a: assert property (ch6_out.sleep_enter_hw |-> $past(ch6_hwen_assigned))
    else $error("sleep entry slot without hardware enable");
  sysrst_pulse_a: assert property (ch7_out.sys_reset_req
    |-> $past(ch7_uv_pin, 2) ##1 !ch7_out.sys_reset_req)
    else $error("system reset request malformed");
  uv_shutdown_a: assert property (ch7_out.uv_reg_off |-> ch7_out.force_off)
    else $error("undervoltage shutdown left channel on");
  uv_latch_cause_a: assert property ($rose(ch7_out.uv_reg_off)
    |-> $past(ch7_uv_pin, 3) && !$past(ch7_uv_pin, 4))
    else $error("shutdown latch without a fresh undervoltage edge");
  ch6_volt_range_a: assert property ($past(rst_n) |-> ch6_out.sleep_mv inside
    {[12'd900:12'd3300]} && ch6_out.sleep_mv % 50 == 0) else $error("channel a voltage off ladder");
  ch7_volt_range_a: assert property ($past(rst_n) |-> ch7_out.volt_mv inside
    {[12'd1000:12'd3500]} && ch7_out.volt_mv % 50 == 0) else $error("channel b voltage off ladder");

  sysrst_c: cover property (ch7_out.sys_reset_req);
  uvoff_c: cover property (ch7_out.uv_reg_off);
  irq_c: cover property ($rose(irq));
  hwctl_c: cover property (ch7_out.hwctl_active);
endmodule : lscr_regs_asserts

// file: test/lscr_regs_tb.sv
// lscr_regs_tb: register-port sequences with expected values for the control bank
// assumes the bank answers reads one cycle later; ce drops once near the end
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); end end
module lscr_regs_tb;
  import lscr_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            ce = 1'b1;
  logic [15:0]     reg_addr = 16'h0000;
  logic [15:0]     reg_wdata = 16'h0000;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [15:0]     reg_rdata;
  logic            hwen = 1'b0;
  logic            h1 = 1'b0;
  logic            h2 = 1'b0;
  logic            uv = 1'b0;
  lscr_ch6_out_t   ch6_out;
  lscr_ch7_out_t   ch7_out;
  logic            irq;
  int              num_errors = 0;
  int              checked = 0;
  int              n_sysrst = 0;
  logic [15:0]     rv;

  lscr_regs i_lscr_regs (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ch6_hwen_assigned(hwen), .hwctl1_pin(h1), .hwctl2_pin(h2), .ch7_uv_pin(uv),
    .ch6_out(ch6_out), .ch7_out(ch7_out), .irq(irq));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (ch7_out.sys_reset_req === 1'b1) n_sysrst++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // own ladders: fine steps up to the knee, then 100 mV from 1.7 V
  function automatic logic [11:0] mv6(input int c);
    return (c <= 14) ? 12'(900 + 50 * c) : 12'(1700 + 100 * (c - 15));
  endfunction : mv6
  function automatic logic [11:0] mv7(input int c);
    return (c <= 12) ? 12'(1000 + 50 * c) : 12'(1700 + 100 * (c - 13));
  endfunction : mv7

  task automatic end_sim;
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    int vc[5];
    int act[7][4];
    vc = '{0, 1, 14, 15, 31};
    act = '{'{0, 1, 1, 0}, '{1, 1, 0, 1}, '{1, 0, 1, 0}, '{2, 0, 1, 1},
            '{2, 1, 0, 0}, '{3, 0, 1, 1}, '{3, 0, 0, 0}};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CH6_SLEEP, rv); `CHK(rv, 16'h0100)
    rd(ADDR_CH7_CTRL, rv); `CHK(rv, 16'h0200)
    rd(ADDR_CH7_ON, rv); `CHK(rv, 16'h0000)
    wr(ADDR_CH6_SLEEP, 16'hffff);
    wr(ADDR_CH7_CTRL, 16'hffff);
    wr(ADDR_CH7_ON, 16'hffff);
    wr(16'h4000, 16'hffff);
    rd(ADDR_CH6_SLEEP, rv); `CHK(rv, 16'he11f)
    rd(ADDR_CH7_CTRL, rv); `CHK(rv, 16'hdfc0)
    rd(ADDR_CH7_ON, rv); `CHK(rv, 16'he11f)
    rd(16'h4000, rv); `CHK(rv, 16'h0000)
    wr(ADDR_CH7_CTRL, 16'h00c0);
    tick(2);
    `CHK({ch7_out.output_float, ch7_out.switch_mode}, 2'b11)
    wr(ADDR_CH7_CTRL, 16'h0000);
    tick(2);
    `CHK({ch7_out.output_float, ch7_out.switch_mode}, 2'b00)
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge ref_clk);
        hwen <= h[0];
        wr(ADDR_CH6_SLEEP, 16'((c << 13) | (h << 8)));
        tick(2);
        `CHK(ch6_out.sleep_slot, 3'((c == 0) ? 5 : (c == 6) ? 3 : (c == 7) ? 1 : 6 - c))
        `CHK(ch6_out.sleep_off, (c inside {[1:5]}) && h == 0)
        `CHK(ch6_out.sleep_enter_hw, (c inside {[1:5]}) && h == 1)
        `CHK(ch6_out.sleep_lowpower, h[0])
        wr(ADDR_CH7_ON, 16'((c << 13) | (h << 8)));
        tick(2);
        `CHK(ch7_out.poweron_slot, 3'((c inside {[1:5]}) ? c : 0))
        `CHK(ch7_out.hwen_sel, 2'((c == 6) ? 1 : (c == 7) ? 2 : 0))
        `CHK(ch7_out.lowpower, h[0])
      end
    end
    foreach (vc[i]) begin
      wr(ADDR_CH6_SLEEP, 16'(vc[i]));
      wr(ADDR_CH7_ON, 16'(vc[i]));
      tick(2);
      `CHK(ch6_out.sleep_mv, mv6(vc[i]))
      `CHK(ch7_out.volt_mv, mv7(vc[i]))
    end
    wr(ADDR_CH7_ON, 16'h000d);
    wr(ADDR_CH7_SLEEP, 16'hffff);
    rd(ADDR_CH7_SLEEP, rv); `CHK(rv, 16'h001f)
    foreach (act[i]) begin
      wr(ADDR_CH7_CTRL, 16'((act[i][0] << 11) | 16'h0400));
      @(posedge ref_clk);
      h1 <= act[i][1][0];
      h2 <= act[i][2][0];
      tick(5);
      `CHK(ch7_out.hwctl_active, act[i][3][0])
      `CHK(ch7_out.volt_mv, (act[i][3] == 1) ? 12'd3500 : 12'd1700)
      `CHK(ch7_out.lowpower, act[i][3][0])
    end
    @(posedge ref_clk);
    h1 <= 1'b1;
    wr(ADDR_CH7_CTRL, 16'h0900);
    tick(5);
    `CHK(ch7_out.force_off, 1'b1)
    wr(ADDR_CH7_CTRL, 16'h0b00);
    tick(2);
    `CHK({ch7_out.force_off, ch7_out.lowpower}, 2'b00)
    @(posedge ref_clk);
    h1 <= 1'b0;
    tick(5);
    rd(ADDR_IRQ_STAT, rv); `CHK(rv, 16'h0002)
    wr(ADDR_IRQ_CLR, 16'h0003);
    wr(ADDR_IRQ_EN, 16'h0001);
    rd(ADDR_IRQ_EN, rv); `CHK(rv, 16'h0001)
    rd(ADDR_IRQ_CLR, rv); `CHK(rv, 16'h0000)
    rd(ADDR_IRQ_STAT, rv); `CHK(rv, 16'h0000)
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_CH7_CTRL, 16'(a << 14));
      @(posedge ref_clk);
      uv <= 1'b1;
      tick(5);
      `CHK(irq, 1'b1)
      `CHK(ch7_out.uv_reg_off, a == 1)
      rd(ADDR_IRQ_STAT, rv); `CHK(rv[0], 1'b1)
      @(posedge ref_clk);
      uv <= 1'b0;
      tick(4);
      wr(ADDR_IRQ_CLR, 16'h0001);
      tick(2);
      `CHK({irq, ch7_out.uv_reg_off}, 2'b00)
    end
    `CHK(n_sysrst, 1)
    wr(ADDR_IRQ_EN, 16'h0000);
    @(posedge ref_clk);
    uv <= 1'b1;
    tick(5);
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STAT, rv); `CHK(rv[0], 1'b1)
    // clock enable low: strobes are dropped and all state holds
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(ADDR_CH7_CTRL, 16'h00c0);
    @(posedge ref_clk);
    ce <= 1'b1;
    tick(2);
    `CHK({ch7_out.output_float, ch7_out.switch_mode}, 2'b00)
    rd(ADDR_CH7_CTRL, rv); `CHK(rv, 16'hc000)
    end_sim();
  end
endmodule : lscr_regs_tb

bind lscr_regs lscr_regs_asserts i_lscr_regs_asserts (.ref_clk, .rst_n, .ce, .reg_addr,
  .reg_rd, .reg_rdata, .ch6_hwen_assigned, .ch7_uv_pin, .ch6_out, .ch7_out, .irq);
